// >>> hdl/vec_pkg.sv
package vec_pkg;
   // Condition codes, one per pin per vector
   typedef enum logic [3:0] {
      CODE_X, CODE_0, CODE_1, CODE_B, CODE_C, CODE_F,
      CODE_H, CODE_K, CODE_L, CODE_N, CODE_P, CODE_Z
   } cond_t;
   localparam int PINS_DEF     = 24;
   localparam int DEPTH_DEF    = 64;
   localparam int PULSE_CYC    = 2;
   localparam logic [1:0] FUSE_BLOWN  = 2'h1;
   localparam logic [1:0] FUSE_INTACT = 2'h2;
   // Result reported after a test
   typedef struct packed {
      logic       done;
      logic       pass;
      logic [7:0] vec;
      logic [7:0] pin;
   } result_t;
endpackage

// >>> hdl/pld_test_vector_applier.sv
// Behaviour
// R1: Store holds one column per device pin, one full vector per row.
// R2: First pass drives code 0 low, code 1 high, X left undriven.
// R3: First pass releases all output pins to sensing state.
// R4: Preload codes P and B are applied in first pass before clocks.
// R5: Second pass pulses all clock-coded pins together.
// R6: Code C pulses low-high-low; code K pulses high-low-high.
// R7: Third pass compares outputs: H expects high, L expects low.
// R8: Code Z fails when the pin is seen driven.
// R9: Code F leaves the pin floating.
// R10: Code X is the default, don't-care on inputs, unchecked on outputs.
// R11: Code N neither drives nor checks the pin.
// R12: Passes repeat per vector until last vector or a failure.
// R13: Report failing vector and pin, or pass when all vectors pass.
// R14: All pin levels of a vector change in the same cycle.
// R15: Fusemap cells accept only blown or intact values, others rejected.
// R16: Vectors arriving with a fusemap load are written to the store.
// R17: Writer places an initialization vector first when needed.
// R18: Failing vector and pin held until next start, cleared at start.
module pld_test_vector_applier #(
   parameter int PINS  = vec_pkg::PINS_DEF,
   parameter int DEPTH = vec_pkg::DEPTH_DEF,
   parameter int FUSES = 256
) (
   input  wire logic                         CLK_SYS_IN,
   input  wire logic                         RST_IN,
   input  wire logic                         START_IN,
   input  wire logic [7:0]                   NUM_VEC_IN,
   input  wire logic                         VEC_WR_IN,
   input  wire logic [$clog2(DEPTH)-1:0]     VEC_ADDR_IN,
   input  wire logic [PINS-1:0][3:0]         VEC_DATA_IN,
   input  wire logic                         FUSE_WR_IN,
   input  wire logic [$clog2(FUSES)-1:0]     FUSE_ADDR_IN,
   input  wire logic [1:0]                   FUSE_DATA_IN,
   input  wire logic [$clog2(FUSES)-1:0]     FUSE_RD_ADDR_IN,
   input  wire logic [PINS-1:0]              PIN_IN,
   input  wire logic [PINS-1:0]              PIN_DRIVEN_IN,
   output logic [PINS-1:0]                   PIN_OUT,
   output logic [PINS-1:0]                   PIN_OE_OUT,
   output logic [PINS-1:0]                   PRELOAD_OUT,
   output logic [PINS-1:0]                   BURIED_OUT,
   output logic                              FUSE_REJECT_OUT,
   output logic                              FUSE_RD_OUT,
   output logic                              BUSY_OUT,
   output vec_pkg::result_t                  RESULT_OUT
);
   typedef enum {
      S_IDLE, S_DRIVE, S_CLK_A, S_CLK_B, S_CLK_C, S_CHECK
   } state_t;
   localparam int              VW       = $clog2(DEPTH);
   localparam int              TW       = $clog2(vec_pkg::PULSE_CYC + 1);
   localparam logic [7:0]      NO_VEC   = 8'h00;
   localparam logic [7:0]      LAST_VEC = 8'h01;
   localparam logic [7:0]      NO_PIN   = 8'h00;
   localparam logic [TW-1:0]   TMR_END  = TW'(vec_pkg::PULSE_CYC - 1);

   state_t                  state_ff;
   logic [PINS-1:0][3:0]    store_ff [DEPTH];
   logic [FUSES-1:0]        fuse_ff;
   logic [VW-1:0]           vidx_ff;
   logic [7:0]              count_ff;
   logic [TW-1:0]           tmr_ff;
   logic [PINS-1:0][3:0]    cur;
   logic                    mis;
   logic [7:0]              mis_pin;
   logic                    tmr_done;
   logic                    idle;
   logic                    start_ok;
   logic                    launch;
   logic                    in_phase;
   logic                    last_row;
   logic                    next_row;
   logic                    run_end;
   logic                    fuse_bad;

   // Run control decodes
   assign cur      = store_ff[vidx_ff];
   assign tmr_done = (tmr_ff == TMR_END);
   assign idle     = (state_ff == S_IDLE);
   assign start_ok = START_IN && (NUM_VEC_IN != NO_VEC);
   assign launch   = idle && start_ok;
   assign in_phase = (state_ff != S_IDLE) && (state_ff != S_CHECK);
   assign last_row = (count_ff == LAST_VEC);
   assign next_row = (state_ff == S_CHECK) && !mis && !last_row;
   assign run_end  = (state_ff == S_CHECK) && (mis || last_row);
   assign fuse_bad = (FUSE_DATA_IN != vec_pkg::FUSE_BLOWN) &&
                     (FUSE_DATA_IN != vec_pkg::FUSE_INTACT);

   // Vector store, also filled by file load [R1] [R16]
   always_ff @(posedge CLK_SYS_IN) begin
      if (VEC_WR_IN) begin
         store_ff[VEC_ADDR_IN] <= VEC_DATA_IN; // [R1] [R16]
      end
   end

   // Fusemap cells, reset to intact [R15]
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         fuse_ff <= '1;
      end else if (FUSE_WR_IN) begin
         if (FUSE_DATA_IN == vec_pkg::FUSE_BLOWN) begin
            fuse_ff[FUSE_ADDR_IN] <= 1'b0; // [R15]
         end else if (FUSE_DATA_IN == vec_pkg::FUSE_INTACT) begin
            fuse_ff[FUSE_ADDR_IN] <= 1'b1; // [R15]
         end
      end
   end

   // Reject pulse, cell left unchanged [R15]
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         FUSE_REJECT_OUT <= 1'b0;
      end else begin
         FUSE_REJECT_OUT <= FUSE_WR_IN && fuse_bad; // [R15]
      end
   end

   // Fuse cell readback, one cycle late
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         FUSE_RD_OUT <= 1'b0;
      end else begin
         FUSE_RD_OUT <= fuse_ff[FUSE_RD_ADDR_IN];
      end
   end

   // Compare sensed outputs [R7] [R8] [R10] [R11]
   always_comb begin
      mis     = 1'b0;
      mis_pin = NO_PIN;
      for (int i = PINS - 1; i >= 0; i--) begin
         case (vec_pkg::cond_t'(cur[i]))
            vec_pkg::CODE_H: begin
               if (!PIN_IN[i]) begin
                  mis     = 1'b1; // [R7]
                  mis_pin = 8'(i);
               end
            end
            vec_pkg::CODE_L: begin
               if (PIN_IN[i]) begin
                  mis     = 1'b1; // [R7]
                  mis_pin = 8'(i);
               end
            end
            vec_pkg::CODE_Z: begin
               if (PIN_DRIVEN_IN[i]) begin
                  mis     = 1'b1; // [R8]
                  mis_pin = 8'(i);
               end
            end
            default: ; // [R10] [R11]
         endcase
      end
   end

   // Three-pass sequencer [R12]
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         state_ff <= S_IDLE;
      end else begin
         case (state_ff)
            S_IDLE: begin
               if (start_ok) begin
                  state_ff <= S_DRIVE;
               end
            end
            S_DRIVE: begin
               if (tmr_done) begin
                  state_ff <= S_CLK_A; // [R4]
               end
            end
            S_CLK_A: begin
               if (tmr_done) begin
                  state_ff <= S_CLK_B; // [R5]
               end
            end
            S_CLK_B: begin
               if (tmr_done) begin
                  state_ff <= S_CLK_C; // [R5]
               end
            end
            S_CLK_C: begin
               if (tmr_done) begin
                  state_ff <= S_CHECK;
               end
            end
            S_CHECK: begin
               if (run_end) begin
                  state_ff <= S_IDLE; // [R12]
               end else begin
                  state_ff <= S_DRIVE; // [R12]
               end
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // Phase timer, restarted at every phase change
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN || !in_phase || tmr_done) begin
         tmr_ff <= '0;
      end else begin
         tmr_ff <= tmr_ff + 1'b1;
      end
   end

   // Row pointer and vectors still to run [R1] [R12]
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         vidx_ff  <= '0;
         count_ff <= NO_VEC;
      end else if (launch) begin
         vidx_ff  <= '0;
         count_ff <= NUM_VEC_IN;
      end else if (next_row) begin
         vidx_ff  <= vidx_ff + 1'b1; // [R12]
         count_ff <= count_ff - 1'b1;
      end
   end

   // Pin drive, all pins updated in one cycle [R14]
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         PIN_OUT     <= '0;
         PIN_OE_OUT  <= '0;
      end else begin
         for (int i = 0; i < PINS; i++) begin
            case (vec_pkg::cond_t'(cur[i]))
               vec_pkg::CODE_0: begin
                  PIN_OUT[i]    <= 1'b0; // [R2] [R14]
                  PIN_OE_OUT[i] <= (state_ff != S_IDLE);
               end
               vec_pkg::CODE_1: begin
                  PIN_OUT[i]    <= 1'b1; // [R2] [R14]
                  PIN_OE_OUT[i] <= (state_ff != S_IDLE);
               end
               vec_pkg::CODE_C: begin
                  PIN_OUT[i]    <= (state_ff == S_CLK_B); // [R5] [R6]
                  PIN_OE_OUT[i] <= (state_ff != S_IDLE);
               end
               vec_pkg::CODE_K: begin
                  PIN_OUT[i]    <= (state_ff != S_CLK_B); // [R5] [R6]
                  PIN_OE_OUT[i] <= (state_ff != S_IDLE);
               end
               default: begin
                  PIN_OUT[i]    <= 1'b0;
                  PIN_OE_OUT[i] <= 1'b0; // [R3] [R9] [R10] [R11]
               end
            endcase
         end
      end
   end

   // Preload strobes during the first pass only [R4]
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         PRELOAD_OUT <= '0;
         BURIED_OUT  <= '0;
      end else begin
         for (int i = 0; i < PINS; i++) begin
            PRELOAD_OUT[i] <= (state_ff == S_DRIVE) &&
                              (vec_pkg::cond_t'(cur[i]) == vec_pkg::CODE_P); // [R4]
            BURIED_OUT[i]  <= (state_ff == S_DRIVE) &&
                              (vec_pkg::cond_t'(cur[i]) == vec_pkg::CODE_B); // [R4]
         end
      end
   end

   // Busy from the start edge until the run is over
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         BUSY_OUT <= 1'b0;
      end else begin
         BUSY_OUT <= !idle || start_ok;
      end
   end

   // Result and failure latch [R13] [R18]
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         RESULT_OUT <= '0;
      end else if (idle && START_IN) begin
         RESULT_OUT <= '0; // [R18]
         if (NUM_VEC_IN == NO_VEC) begin
            RESULT_OUT.done <= 1'b1; // [R13]
            RESULT_OUT.pass <= 1'b1;
         end
      end else if (run_end) begin
         RESULT_OUT.done <= 1'b1; // [R13]
         if (mis) begin
            RESULT_OUT.vec <= 8'(vidx_ff); // [R13]
            RESULT_OUT.pin <= mis_pin;
         end else begin
            RESULT_OUT.pass <= 1'b1;
         end
      end
   end
endmodule

// >>> test/dut_model.sv
module dut_model (
   input  wire logic [7:0] pin_out_in,
   input  wire logic [7:0] pin_oe_in,
   input  wire logic [7:0] drv_in,
   input  wire logic [7:0] val_in,
   output logic      [7:0] level_out,
   output logic      [7:0] driven_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Undriven pins read the model value where drv_in is set, and its inverse where it is not
   assign level_out  = (pin_oe_in & pin_out_in) | (~pin_oe_in & ~(drv_in ^ val_in));
   assign driven_out = drv_in & ~pin_oe_in;
endmodule

// >>> test/pld_test_vector_applier_sva.sv
module pld_tva_sva #(
   parameter int PINS  = 24,
   parameter int DEPTH = 64,
   parameter int FUSES = 256
) (
   input wire logic             CLK_SYS_IN,
   input wire logic             RST_IN,
   input wire logic             START_IN,
   input wire logic [7:0]       NUM_VEC_IN,
   input wire logic             FUSE_WR_IN,
   input wire logic [1:0]       FUSE_DATA_IN,
   input wire logic [PINS-1:0]  PRELOAD_OUT,
   input wire logic             FUSE_REJECT_OUT,
   input wire logic             BUSY_OUT,
   input wire vec_pkg::result_t RESULT_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] HANG_LIM = 12'h960;
   logic [11:0] wait_cyc_ff;
   // Cycles spent busy without a result
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN || !BUSY_OUT || RESULT_OUT.done) begin
         wait_cyc_ff <= '0;
      end else if (wait_cyc_ff != '1) begin
         wait_cyc_ff <= wait_cyc_ff + 1'b1;
      end
   end
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);
   start_busy_a: assert property (START_IN && !BUSY_OUT && NUM_VEC_IN != 8'h0 |=> BUSY_OUT)
      else $error("busy not raised");
   start_clear_a: assert property (START_IN && !BUSY_OUT && NUM_VEC_IN != 8'h0 |=>
      RESULT_OUT == '0) else $error("result not cleared");
   result_hold_a: assert property (!BUSY_OUT && RESULT_OUT.done && !START_IN |=>
      $stable(RESULT_OUT)) else $error("result changed");
   busy_done_a: assert property ($fell(BUSY_OUT) |-> RESULT_OUT.done)
      else $error("no done at end");
   empty_pass_a: assert property (START_IN && !BUSY_OUT && NUM_VEC_IN == 8'h0 |->
      ##[1:3] (RESULT_OUT.done && RESULT_OUT.pass)) else $error("empty run");
   test_bound_a: assert property (wait_cyc_ff < HANG_LIM)
      else $error("test hung");
   fuse_reject_a: assert property (FUSE_WR_IN &&
      (FUSE_DATA_IN == 2'h0 || FUSE_DATA_IN == 2'h3)
      |=> FUSE_REJECT_OUT) else $error("bad fuse kept");
   fuse_accept_a: assert property (FUSE_WR_IN &&
      (FUSE_DATA_IN == 2'h1 || FUSE_DATA_IN == 2'h2)
      |=> !FUSE_REJECT_OUT) else $error("good fuse refused");
   preload_busy_a: assert property (PRELOAD_OUT != '0 |-> BUSY_OUT)
      else $error("preload while idle");
endmodule
bind pld_test_vector_applier pld_tva_sva #(.PINS(PINS), .DEPTH(DEPTH), .FUSES(FUSES)) i_sva (
   .CLK_SYS_IN, .RST_IN, .START_IN, .NUM_VEC_IN, .FUSE_WR_IN, .FUSE_DATA_IN, .PRELOAD_OUT,
   .FUSE_REJECT_OUT, .BUSY_OUT, .RESULT_OUT);

// >>> test/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst = 1, start = 0, vec_wr = 0, fuse_wr = 0, rej, frd, busy;
   logic [7:0] num_vec = 0, drv = 0, val = 0, pin_out, pin_oe, pin_in, pin_drv, pre, bur;
   logic [3:0] vec_addr = 0, fuse_addr = 0, fuse_rd = 0;
   logic [7:0][3:0] vec_data = 0, v;
   logic [7:0][3:0] mem [16];
   logic [1:0] fuse_data = 0;
   vec_pkg::result_t res;
   integer seed = 16, n_fail = 0, tests_run = 0, nv;
   pld_test_vector_applier #(.PINS(8), .DEPTH(16), .FUSES(16)) i_pld_test_vector_applier (
      .CLK_SYS_IN(clk), .RST_IN(rst), .START_IN(start), .NUM_VEC_IN(num_vec),
      .VEC_WR_IN(vec_wr), .VEC_ADDR_IN(vec_addr), .VEC_DATA_IN(vec_data),
      .FUSE_WR_IN(fuse_wr), .FUSE_ADDR_IN(fuse_addr), .FUSE_DATA_IN(fuse_data),
      .FUSE_RD_ADDR_IN(fuse_rd), .PIN_IN(pin_in), .PIN_DRIVEN_IN(pin_drv), .PIN_OUT(pin_out),
      .PIN_OE_OUT(pin_oe), .PRELOAD_OUT(pre), .BURIED_OUT(bur), .FUSE_REJECT_OUT(rej),
      .FUSE_RD_OUT(frd), .BUSY_OUT(busy), .RESULT_OUT(res));
   dut_model i_dut_model (.pin_out_in(pin_out), .pin_oe_in(pin_oe), .drv_in(drv),
      .val_in(val), .level_out(pin_in), .driven_out(pin_drv));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task print_verdict;
      if (n_fail == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task wr(input int a, input logic [7:0][3:0] d);
      @(posedge clk);
      vec_wr <= 1;
      vec_addr <= a[3:0];
      vec_data <= d;
      mem[a] = d;
      @(posedge clk);
      vec_wr <= 0;
   endtask
   function logic [16:0] expect_res(int n);
      logic lvl;
      for (int k = 0; k < n; k++) for (int i = 0; i < 8; i++) begin
         lvl = ~(drv[i] ^ val[i]);
         if ((mem[k][i] == vec_pkg::CODE_H && !lvl) || (mem[k][i] == vec_pkg::CODE_L && lvl) ||
            (mem[k][i] == vec_pkg::CODE_Z && drv[i])) return {1'b0, 8'(k), 8'(i)};
      end
      return 17'h10000;
   endfunction
   task run(input int n, input bit pins);
      @(posedge clk);
      num_vec <= n[7:0];
      start <= 1;
      @(posedge clk);
      start <= 0;
      if (pins) begin
         repeat (2) @(posedge clk);
         #1 chk("oe", pin_oe, 8'h0f);
         chk("drive", pin_out[3:0], 4'b1010);
         chk("preload", {pre, bur}, 16'h2040);
         repeat (4) @(posedge clk);
         #1 chk("clock", pin_out[3:0], 4'b0110);
      end
      repeat (3000) begin
         @(posedge clk);
         #1 if (res.done === 1'b1 && busy === 1'b0) break;
      end
      chk("done", res.done, 1'b1);
      chk("result", {res.pass, res.pass ? 16'h0 : {res.vec, res.pin}}, expect_res(n));
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      print_verdict;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      // Model holds no state, so no initialization vector is needed
      wr(0, {vec_pkg::CODE_H, vec_pkg::CODE_B, vec_pkg::CODE_P, vec_pkg::CODE_F,
         vec_pkg::CODE_K, vec_pkg::CODE_C, vec_pkg::CODE_1, vec_pkg::CODE_0});
      drv <= 8'h80;
      val <= 8'h80;
      run(1, 1);
      run(0, 0);
      repeat (8) begin
         nv = 1 + $unsigned($random(seed)) % 4;
         for (int k = 0; k < nv; k++) begin
            for (int i = 0; i < 8; i++) v[i] = 4'($unsigned($random(seed)) % 12);
            wr(k, v);
         end
         drv <= $random(seed);
         val <= $random(seed);
         run(nv, 0);
      end
      for (int d = 0; d < 4; d++) begin
         @(posedge clk);
         fuse_wr <= 1;
         fuse_addr <= 4'h5;
         fuse_data <= 2'(d ^ 1);
         @(posedge clk);
         fuse_wr <= 0;
         fuse_rd <= 4'h5;
         #1 chk("reject", rej, d == 1 || d == 2);
         @(posedge clk);
         #1 chk("fuse", frd, d == 3);
      end
      print_verdict;
   end
endmodule
